/* verilog/bus_space_decoder.v */
// bus space decoder with its configuration register bank
// assumes an AHB-Lite master for registers, a cpu address strobe,
// and a power-on reset distinct from the manual reset input
`timescale 1ns/100ps
`include "bus_space_decoder_regs.vh"

module bus_space_decoder (
    input  wire        i_clk,          // 125 MHz system clock
    input  wire        i_arst_n,       // power-on reset, async, low
    input  wire        i_manual_rst,   // manual reset, registers keep
    input  wire        i_standby,      // standby, registers frozen
    input  wire        i_hsel,         // ahb slave select
    input  wire [31:0] i_haddr,        // ahb address
    input  wire [1:0]  i_htrans,       // ahb transfer type
    input  wire        i_hwrite,       // ahb write
    input  wire [2:0]  i_hsize,        // ahb size
    input  wire [31:0] i_hwdata,       // ahb write data
    input  wire        i_hready,       // ahb bus ready
    output reg  [31:0] o_hrdata,       // ahb read data
    output reg         o_hreadyout,    // ahb slave ready
    output reg         o_hresp,        // ahb response, always okay
    input  wire        i_cpu_req,      // cpu access strobe
    input  wire [31:0] i_cpu_addr,     // cpu 32-bit address
    input  wire        i_rom_en,       // on-chip rom in use
    input  wire        i_single_chip,  // single-chip mode
    input  wire        i_mode_wide,    // mode pin for area zero width
    input  wire        i_big_pkg,      // largest package variant
    output reg  [3:0]  o_space,        // decoded space code
    output reg  [1:0]  o_bus_width,    // width code 8/16/32
    output reg  [21:0] o_ext_addr,     // external address pins
    output reg         o_area_zero_select_n,  // area zero select
    output reg         o_area_one_select_n,   // area one select
    output reg         o_area_two_select_n,   // area two select
    output reg         o_area_three_select_n, // area three select
    output reg         o_area3_mux,    // area three multiplexed
    output reg         o_pulse_timer_unit_en, // timer reg access enable
    output reg         o_dec_valid     // decode result valid pulse
);

    // **************************************************************
    // register bank
    // **************************************************************
    reg [15:0] regs_q [0:7];           // eight 16-bit registers
    reg        ctrl_q;                 // manual reset latch status
    reg        wr_pend_q;              // data phase of a write
    reg [3:0]  wr_idx_q;               // register slot of write, 15 = unmapped
    reg [2:0]  wr_size_q;              // size of write
    reg [1:0]  wr_lane_q;              // byte address bits
    reg        rd_pend_q;              // data phase of a read
    reg [31:0] rd_addr_q;              // offset from register base of the access, read or write
    integer    k;

    wire [31:0] rel_addr = i_haddr - `BSD_REG_BASE;
    wire        acc = i_hsel && i_hready && i_htrans[1];

    // map halfword index to register slot, 15 = unmapped
    function [3:0] slot;
        input [31:0] ofs;
        begin
            case (ofs[7:1])
                7'h00: slot = 4'h0;
                7'h01: slot = 4'h1;
                7'h02: slot = 4'h2;
                7'h03: slot = 4'h3;
                7'h05: slot = 4'h4;
                7'h06: slot = 4'h5;
                7'h07: slot = 4'h6;
                7'h08: slot = 4'h7;
                default: slot = 4'hF;
            endcase
            if (ofs[31:8] != 24'h0)
                slot = 4'hF;
        end
    endfunction

    // reset value per slot
    function [15:0] rst_val;
        input [2:0] s;
        begin
            case (s)
                3'h0: rst_val = `BSD_RST_BCFG1;
                3'h1: rst_val = `BSD_RST_BCFG2;
                3'h2: rst_val = `BSD_RST_WAIT1;
                3'h3: rst_val = `BSD_RST_WAIT2;
                3'h4: rst_val = `BSD_RST_DRAMC;
                3'h5: rst_val = `BSD_RST_RFCS;
                3'h6: rst_val = `BSD_RST_RFCNT;
                default: rst_val = `BSD_RST_RFCOR;
            endcase
        end
    endfunction

    // write data of one halfword slot given lane bytes
    wire [15:0] wsel_hw = wr_lane_q[1] ? i_hwdata[31:16] : i_hwdata[15:0];

    // **************************************************************
    // ahb data phase and register writes
    // **************************************************************
    // only power-on reset clears; manual reset and standby hold
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (k = 0; k < 8; k = k + 1)
                regs_q[k] <= rst_val(k[2:0]);
            wr_pend_q   <= 1'b0;
            wr_idx_q    <= 4'h0;
            wr_size_q   <= 3'h0;
            wr_lane_q   <= 2'h0;
            rd_pend_q   <= 1'b0;
            rd_addr_q   <= 32'h0;
            ctrl_q      <= 1'b0;
        end else begin
            wr_pend_q <= acc && i_hwrite;
            rd_pend_q <= acc && !i_hwrite;
            if (acc) begin
                wr_idx_q  <= slot(rel_addr);
                wr_size_q <= i_hsize;
                wr_lane_q <= i_haddr[1:0];
                rd_addr_q <= rel_addr;
            end
            if (i_manual_rst)
                ctrl_q <= 1'b1;        // manual reset seen
            // writes ignored in standby
            if (wr_pend_q && !i_standby) begin
                if (wr_size_q == 3'h2) begin
                    // word access: both halfwords of the word
                    write_hw(slot({rd_addr_q[31:2], 2'h0}), i_hwdata[15:0], 2'h3);
                    write_hw(slot({rd_addr_q[31:2], 2'h2}), i_hwdata[31:16], 2'h3);
                end else if (wr_size_q == 3'h1) begin
                    write_hw(wr_idx_q, wsel_hw, 2'h3);
                end else begin
                    // odd byte address sits on the high byte lane
                    write_hw(wr_idx_q, wsel_hw, wr_lane_q[0] ? 2'h2 : 2'h1);
                end
            end
        end
    end

    // halfword write with byte enables (bit1 = high byte)
    task write_hw;
        input [3:0]  s;
        input [15:0] v;
        input [1:0]  be;
        reg   [15:0] m;
        begin
            m = {{8{be[1]}}, {8{be[0]}}};
            if (s == 4'h0)
                m = m & `BSD_BCFG1_WMASK;
            if (s[3] == 1'b0)
                regs_q[s[2:0]] <= (regs_q[s[2:0]] & ~m) | (v & m);
        end
    endtask

    // read mux: word returns the aligned halfword pair
    wire [3:0]  rs_lo = slot({rd_addr_q[31:2], 2'h0});
    wire [3:0]  rs_hi = slot({rd_addr_q[31:2], 2'h2});
    wire [15:0] rd_lo = (rs_lo[3] == 1'b0) ? regs_q[rs_lo[2:0]] : 16'h0000;
    wire [15:0] rd_hi = (rs_hi[3] == 1'b0) ? regs_q[rs_hi[2:0]] : 16'h0000;
    wire [31:0] ctrl_word = {31'h0, ctrl_q};
    wire        is_ctrl = (rd_addr_q == (`BSD_OFS_CTRL - `BSD_REG_BASE));

    // **************************************************************
    // bus outputs
    // **************************************************************
    // writes zero wait; reads get one wait state so that the
    // registered read data stands at the end of the data phase
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_hrdata    <= 32'h0;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= !(acc && !i_hwrite);
            o_hresp     <= 1'b0;
            if (acc && !i_hwrite)
                o_hrdata <= 32'h0;
            if (rd_pend_q)
                o_hrdata <= is_ctrl ? ctrl_word : {rd_hi, rd_lo};
        end
    end

    // **************************************************************
    // address decode
    // **************************************************************
    wire [15:0] b1 = regs_q[0];
    reg  [3:0]  sp_d;
    reg  [1:0]  w_d;

    // width of an ordinary area from long/size bits
    function [1:0] area_w;
        input lg;
        input sz;
        begin
            area_w = lg ? `BSD_W32 : (sz ? `BSD_W16 : `BSD_W8);
        end
    endfunction

    always @* begin
        sp_d = `BSD_SP_RESERVED;
        w_d  = `BSD_W32;
        if (i_cpu_addr[31:24] == 8'h00) begin
            case (i_cpu_addr[23:22])
                2'h0: begin
                    if (i_rom_en) begin
                        if (i_cpu_addr <= `BSD_ROM_TOP)
                            sp_d = `BSD_SP_ROM;
                        else if (i_cpu_addr >= `BSD_AREA0_ROM_BASE) begin
                            sp_d = `BSD_SP_AREA0;
                            w_d  = area_w(b1[4], b1[0]);
                        end
                    end else begin
                        sp_d = `BSD_SP_AREA0;
                        w_d  = i_big_pkg ? (i_mode_wide ? `BSD_W32 : `BSD_W16)
                                         : (i_mode_wide ? `BSD_W16 : `BSD_W8);
                    end
                end
                2'h1: begin
                    sp_d = `BSD_SP_AREA1;
                    w_d  = area_w(b1[5], b1[1]);
                end
                2'h2: begin
                    sp_d = `BSD_SP_AREA2;
                    w_d  = area_w(b1[6], b1[2]);
                end
                default: begin
                    sp_d = `BSD_SP_AREA3;
                    if (b1[`BSD_BIT_MUX_EN])
                        w_d = i_cpu_addr[14] ? `BSD_W16 : `BSD_W8;
                    else
                        w_d = area_w(b1[7], b1[3]);
                end
            endcase
        end else if (i_cpu_addr[31:24] == 8'h01) begin
            sp_d = `BSD_SP_DRAM;
            w_d  = area_w(regs_q[4][1], regs_q[4][0]);
        end else if (i_cpu_addr >= `BSD_RAM_LO) begin
            sp_d = `BSD_SP_RAM;
        end else if (i_cpu_addr >= `BSD_PERIPH_LO && i_cpu_addr <= `BSD_PERIPH_HI) begin
            sp_d = `BSD_SP_PERIPH;
            w_d  = `BSD_W16;
        end
        if (i_single_chip && sp_d >= `BSD_SP_AREA0)
            sp_d = `BSD_SP_RESERVED;
    end

    // **************************************************************
    // registered decode outputs
    // **************************************************************
    // one select at most, only for external areas
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_space               <= `BSD_SP_NONE;
            o_bus_width           <= `BSD_W32;
            o_ext_addr            <= 22'h0;
            o_area_zero_select_n  <= 1'b1;
            o_area_one_select_n   <= 1'b1;
            o_area_two_select_n   <= 1'b1;
            o_area_three_select_n <= 1'b1;
            o_area3_mux           <= 1'b0;
            o_pulse_timer_unit_en <= 1'b1;
            o_dec_valid           <= 1'b0;
        end else begin
            o_dec_valid           <= i_cpu_req;
            o_space               <= i_cpu_req ? sp_d : `BSD_SP_NONE;
            o_bus_width           <= w_d;
            o_ext_addr            <= i_cpu_addr[21:0];
            o_area_zero_select_n  <= !(i_cpu_req && sp_d == `BSD_SP_AREA0);
            o_area_one_select_n   <= !(i_cpu_req && sp_d == `BSD_SP_AREA1);
            o_area_two_select_n   <= !(i_cpu_req && sp_d == `BSD_SP_AREA2);
            o_area_three_select_n <= !(i_cpu_req && sp_d == `BSD_SP_AREA3);
            o_area3_mux           <= b1[`BSD_BIT_MUX_EN];
            o_pulse_timer_unit_en <= b1[`BSD_BIT_TIMER_EN];
        end
    end

endmodule // bus_space_decoder

/* verilog/bus_space_decoder_regs.vh */
// constants of the bus space decoder and its configuration register bank
// assumes a 32-bit AHB-Lite slave port and a single 125 MHz clock
`ifndef BUS_SPACE_DECODER_REGS_VH
`define BUS_SPACE_DECODER_REGS_VH

// **************************************************************
// register byte addresses (halfword index = offset bits 7:1)
// **************************************************************
`define BSD_REG_BASE        32'hFFFF8620
`define BSD_OFS_BCFG1       32'hFFFF8620
`define BSD_OFS_BCFG2       32'hFFFF8622
`define BSD_OFS_WAIT1       32'hFFFF8624
`define BSD_OFS_WAIT2       32'hFFFF8626
`define BSD_OFS_DRAMC       32'hFFFF862A
`define BSD_OFS_RFCS        32'hFFFF862C
`define BSD_OFS_RFCNT       32'hFFFF862E
`define BSD_OFS_RFCOR       32'hFFFF8630
`define BSD_OFS_CTRL        32'hFFFF8640

// **************************************************************
// reset values
// **************************************************************
`define BSD_RST_BCFG1       16'h200F
`define BSD_RST_BCFG2       16'hFFFF
`define BSD_RST_WAIT1       16'hFFFF
`define BSD_RST_WAIT2       16'h000F
`define BSD_RST_DRAMC       16'h0000
`define BSD_RST_RFCS        16'h0000
`define BSD_RST_RFCNT       16'h0000
`define BSD_RST_RFCOR       16'h0000

// **************************************************************
// first bus config register fields
// **************************************************************
`define BSD_BCFG1_WMASK     16'h21FF
`define BSD_BIT_TIMER_EN    13
`define BSD_BIT_MUX_EN      8
`define BSD_BIT_LONG0       4
`define BSD_BIT_SIZE0       0

// **************************************************************
// space codes and width codes
// **************************************************************
`define BSD_SP_NONE         4'h0
`define BSD_SP_ROM          4'h1
`define BSD_SP_RAM          4'h2
`define BSD_SP_PERIPH       4'h3
`define BSD_SP_RESERVED     4'h4
`define BSD_SP_AREA0        4'h5
`define BSD_SP_AREA1        4'h6
`define BSD_SP_AREA2        4'h7
`define BSD_SP_AREA3        4'h8
`define BSD_SP_DRAM         4'h9
`define BSD_W8              2'h0
`define BSD_W16             2'h1
`define BSD_W32             2'h2
`define BSD_ROM_TOP         32'h0003FFFF
`define BSD_AREA0_ROM_BASE  32'h00200000
`define BSD_PERIPH_LO       32'hFFFF8000
`define BSD_PERIPH_HI       32'hFFFF87FF
`define BSD_RAM_LO          32'hFFFFF000

`endif

/* tb/bus_space_decoder_props.sv */
// checker of the decoder ports: space, width and select relations
// assumes a bind onto bus_space_decoder and one clock domain
`timescale 1ns/100ps
module bus_space_decoder_props (
    input wire        i_clk,
    input wire        i_arst_n,
    input wire        o_hreadyout,
    input wire        o_hresp,
    input wire        i_cpu_req,
    input wire [31:0] i_cpu_addr,
    input wire        i_rom_en,
    input wire        i_single_chip,
    input wire        i_mode_wide,
    input wire        i_big_pkg,
    input wire [3:0]  o_space,
    input wire [1:0]  o_bus_width,
    input wire [21:0] o_ext_addr,
    input wire        o_area_zero_select_n,
    input wire        o_area_one_select_n,
    input wire        o_area_two_select_n,
    input wire        o_area_three_select_n,
    input wire        o_area3_mux,
    input wire        o_dec_valid
);
    // ********************************
    // bus response check, then decode relations one cycle after a request
    // ********************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    wire [3:0] sel_n = {o_area_three_select_n, o_area_two_select_n, o_area_one_select_n, o_area_zero_select_n};
    wire       ext = i_cpu_req && i_cpu_addr[31:24] == 8'h00 && !i_single_chip;  // external candidate
    wire       rom_lo = i_rom_en && i_cpu_addr[23:21] == 3'h0;                  // rom or its gap
    a_bus_okay: assert property (!o_hresp && (o_hreadyout || $past(o_hreadyout)))
        else $error("slave stalled or answered error");
    a_addr_out: assert property (i_cpu_req |=> o_dec_valid && o_ext_addr == $past(i_cpu_addr[21:0]))
        else $error("external address not driven from request");
    a_one_select: assert property (o_dec_valid |-> $countones(~sel_n) <= 1)
        else $error("more than one area select active");
    a_area_pick: assert property (ext && !rom_lo |=> sel_n == ~(4'h1 << $past(i_cpu_addr[23:22])))
        else $error("wrong area select for address");
    a_space_nosel: assert property (i_cpu_req && i_cpu_addr[31:24] != 8'h00 |=> sel_n == 4'hF)
        else $error("select raised for internal space");
    a_rom_map: assert property (ext && rom_lo |=> sel_n == 4'hF &&
        o_space == ($past(i_cpu_addr[20:18]) == 3'h0 ? 4'h1 : 4'h4)) else $error("rom map wrong");
    a_single_chip: assert property (i_cpu_req && i_single_chip |=> sel_n == 4'hF)
        else $error("select raised in single-chip mode");
    a_ram_route: assert property (i_cpu_req && i_cpu_addr[31:12] == 20'hFFFFF |=>
        o_space == 4'h2 && o_bus_width == 2'h2) else $error("ram access misrouted");
    a_mux_width: assert property (ext && i_cpu_addr[23:22] == 2'h3 && o_area3_mux |=>
        o_bus_width == {1'b0, $past(i_cpu_addr[14])}) else $error("multiplexed width wrong");
    a_area0_pin: assert property (ext && !i_rom_en && i_cpu_addr[23:22] == 2'h0 |=>
        o_bus_width == {$past(i_big_pkg) & $past(i_mode_wide), $past(i_big_pkg) ^ $past(i_mode_wide)})
        else $error("area zero width not from mode pin");
endmodule // bus_space_decoder_props

/* tb/ext_device_model.sv */
// external device model: records the area and address it is given
// assumes low-active area selects that stand one cycle
`timescale 1ns/100ps
module ext_device_model (
    input  wire        i_clk,   // system clock
    input  wire [3:0]  i_sel_n, // area selects, low active
    input  wire [21:0] i_addr,  // external address pins
    output reg  [1:0]  o_area,  // last area selected
    output reg  [21:0] o_addr   // last address latched
);
    // latch on every selected cycle, one-hot low selects
    always @(posedge i_clk) begin
        if (i_sel_n != 4'hF) begin
            o_area <= {~i_sel_n[3] | ~i_sel_n[2], ~i_sel_n[3] | ~i_sel_n[1]};
            o_addr <= i_addr;
        end
    end
endmodule // ext_device_model

/* tb/bus_space_decoder_bench.sv */
// self-checking bench of the decoder and its register bank
// assumes the checker and the external device model are compiled first
`timescale 1ns/100ps
`include "bus_space_decoder_regs.vh"
module bus_space_decoder_bench;
    logic        i_clk = 1'b0, i_arst_n = 1'b0, i_manual_rst = 1'b0, i_standby = 1'b0;
    logic        i_hsel = 1'b0, i_hwrite = 1'b0, i_cpu_req = 1'b0, i_rom_en = 1'b1;
    logic        i_single_chip = 1'b0, i_mode_wide = 1'b1, i_big_pkg = 1'b1;
    logic [31:0] i_haddr = '0, i_hwdata = '0, i_cpu_addr = '0, o_hrdata, rd;
    logic [1:0]  i_htrans = '0, o_bus_width, p_area;
    logic [2:0]  i_hsize = '0;
    logic [3:0]  o_space;
    logic [21:0] o_ext_addr, p_addr;
    wire         i_hready, o_hreadyout, o_hresp, o_area3_mux, o_pulse_timer_unit_en, o_dec_valid;
    wire         o_area_zero_select_n, o_area_one_select_n, o_area_two_select_n, o_area_three_select_n;
    wire [3:0]   sel_n = {o_area_three_select_n, o_area_two_select_n, o_area_one_select_n, o_area_zero_select_n};
    int          failures = 0, n_compared = 0;
    assign i_hready = o_hreadyout; // single slave drives bus ready
    bus_space_decoder DUT (.*);
    ext_device_model u_model (.i_clk(i_clk), .i_sel_n(sel_n), .i_addr(o_ext_addr), .o_area(p_area), .o_addr(p_addr));
    always #4 i_clk = ~i_clk;
    // ********************************
    // shared tasks
    // ********************************
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one single transfer: address phase, then data phase, then read data
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd);
        int n;
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= a;
        i_hwrite <= wr;
        i_hsize <= sz;
        n = 0;
        do begin @(posedge i_clk); n++; end while (i_hready !== 1'b1 && n < 50);
        if (i_hready !== 1'b1) failures++;
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        n = 0;
        do begin @(posedge i_clk); n++; end while (i_hready !== 1'b1 && n < 50);
        if (i_hready !== 1'b1) failures++;
        rd = o_hrdata; // value sampled at the edge that ends the data phase
    endtask
    // one decode request; width 3 means not checked
    task automatic dec(input logic [31:0] a, input logic [3:0] sp, input logic [1:0] w, input logic [3:0] sel);
        @(posedge i_clk);
        i_cpu_req <= 1'b1;
        i_cpu_addr <= a;
        @(posedge i_clk);
        i_cpu_req <= 1'b0;
        #1 chk(o_space, sp, "space");
        if (w !== 2'h3) chk(o_bus_width, w, "width");
        chk(sel_n, sel, "selects");
        chk(o_ext_addr, a[21:0], "ext addr");
        if (sel != 4'hF) begin
            @(posedge i_clk);
            #1 chk({p_area, p_addr}, {a[23:22], a[21:0]}, "model area");
        end
    endtask
    // ********************************
    // scenarios
    // ********************************
    task test_reset;
        ahb(1'b0, `BSD_OFS_BCFG1, 3'h2, '0);
        chk(rd, 32'hFFFF200F, "bcfg word");
        ahb(1'b0, `BSD_OFS_WAIT1, 3'h2, '0);
        chk(rd, 32'h000FFFFF, "wait word");
        ahb(1'b0, `BSD_OFS_BCFG2, 3'h1, '0);
        chk(rd[31:16], 16'hFFFF, "bcfg two half");
        chk({o_pulse_timer_unit_en, o_area3_mux}, 2'h2, "bcfg fields");
        $display("test reset values done");
    endtask
    task test_sizes;
        ahb(1'b1, `BSD_OFS_WAIT1, 3'h2, 32'hA5A50F0F);
        ahb(1'b1, `BSD_OFS_RFCS + 32'h1, 3'h0, 32'h00005A00);
        ahb(1'b1, `BSD_OFS_RFCNT, 3'h1, 32'h12340000);
        ahb(1'b1, `BSD_OFS_DRAMC, 3'h1, 32'h00020000);
        ahb(1'b1, `BSD_OFS_RFCOR, 3'h2, 32'hFFFFFFFF);
        ahb(1'b1, 32'hFFFF8700, 3'h2, 32'hFFFFFFFF);
        ahb(1'b0, `BSD_OFS_WAIT1, 3'h2, '0);
        chk(rd, 32'hA5A50F0F, "word write");
        ahb(1'b0, `BSD_OFS_RFCS, 3'h2, '0);
        chk(rd, 32'h12345A00, "byte and half write");
        ahb(1'b0, `BSD_OFS_RFCOR, 3'h2, '0);
        chk(rd, 32'h0000FFFF, "sixteen bit register");
        ahb(1'b0, 32'hFFFF8700, 3'h2, '0);
        chk(rd, 32'h0, "unmapped read");
        $display("test access sizes done");
    endtask
    task test_config;
        ahb(1'b1, `BSD_OFS_BCFG1, 3'h2, 32'hFFFFFF2B);
        ahb(1'b0, `BSD_OFS_BCFG1, 3'h1, '0);
        chk(rd[15:0], 16'h212B, "bcfg reserved bits");
        chk({o_pulse_timer_unit_en, o_area3_mux}, 2'h3, "bcfg fields set");
        ahb(1'b1, `BSD_OFS_BCFG1, 3'h1, 32'h0000012B);
        @(posedge i_clk);
        #1 chk(o_pulse_timer_unit_en, 1'b0, "timer enable clear");
        $display("test config done");
    endtask
    task test_decode;
        dec(32'h00000000, 4'h1, 2'h2, 4'hF);
        dec(32'h00100000, 4'h4, 2'h3, 4'hF);
        dec(32'h00200000, 4'h5, 2'h1, 4'hE);
        dec(32'h007FFFFC, 4'h6, 2'h2, 4'hD);
        dec(32'h00800000, 4'h7, 2'h0, 4'hB);
        dec(32'h00C00000, 4'h8, 2'h0, 4'h7);
        dec(32'h00C04000, 4'h8, 2'h1, 4'h7);
        dec(32'h01000000, 4'h9, 2'h2, 4'hF);
        dec(32'h02000000, 4'h4, 2'h3, 4'hF);
        dec(32'hFFFF8000, 4'h3, 2'h1, 4'hF);
        dec(32'hFFFF8800, 4'h4, 2'h3, 4'hF);
        dec(32'hFFFFFFFC, 4'h2, 2'h2, 4'hF);
        i_rom_en <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            i_big_pkg <= k[1];
            i_mode_wide <= k[0];
            dec(32'h00380000, 4'h5, {k[1] & k[0], k[1] ^ k[0]}, 4'hE);
        end
        i_single_chip <= 1'b1;
        dec(32'h00400000, 4'h4, 2'h3, 4'hF);
        dec(32'hFFFFF000, 4'h2, 2'h2, 4'hF);
        i_single_chip <= 1'b0;
        i_rom_en <= 1'b1;
        $display("test decode done");
    endtask
    task test_keep;
        @(posedge i_clk);
        i_manual_rst <= 1'b1;
        @(posedge i_clk);
        i_manual_rst <= 1'b0;
        ahb(1'b0, `BSD_OFS_WAIT1, 3'h2, '0);
        chk(rd, 32'hA5A50F0F, "kept over manual reset");
        ahb(1'b0, `BSD_OFS_CTRL, 3'h2, '0);
        chk(rd, 32'h1, "manual reset status");
        i_standby <= 1'b1;
        ahb(1'b1, `BSD_OFS_WAIT1, 3'h2, '0);
        ahb(1'b0, `BSD_OFS_WAIT1, 3'h2, '0);
        chk(rd, 32'hA5A50F0F, "kept in standby");
        i_standby <= 1'b0;
        @(posedge i_clk);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        ahb(1'b0, `BSD_OFS_BCFG1, 3'h2, '0);
        chk(rd, 32'hFFFF200F, "bcfg after power reset");
        ahb(1'b0, `BSD_OFS_CTRL, 3'h2, '0);
        chk(rd, 32'h0, "status after power reset");
        $display("test reset keep done");
    endtask
    task summarize;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence after 12 cycles of reset
    initial begin
        repeat (12) @(posedge i_clk);
        i_arst_n <= 1'b1;
        test_reset;
        test_sizes;
        test_config;
        test_decode;
        test_keep;
        summarize;
    end
    // watchdog, far beyond the expected run of under two hundred cycles
    initial begin
        #100000;
        failures++;
        summarize;
    end
endmodule // bus_space_decoder_bench
bind bus_space_decoder bus_space_decoder_props u_props (.*);
